/* File: logic/pscd_cfg.svh */
// Constants for the pin strap configuration decoder.
// Assumes a 50 MHz master clock and inclusion by bare name.
`ifndef PSCD_CFG_SVH
`define PSCD_CFG_SVH

`define PSCD_NUM_CH 8
`define PSCD_CLK_PERIOD_NS 20
// Decimation ratios
`define PSCD_DEC_X32 11'h020
`define PSCD_DEC_X64 11'h040
`define PSCD_DEC_X128 11'h080
`define PSCD_DEC_X1024 11'h400
// Modulator clock divisions of the master clock
`define PSCD_MOD_DIV_FAST 6'h04
`define PSCD_MOD_DIV_MEDIAN 6'h08
`define PSCD_MOD_DIV_LOW 6'h20
// Data clock divisions
`define PSCD_DATA_CLOCK_OUT_DIV1 4'h1
`define PSCD_DATA_CLOCK_OUT_DIV2 4'h2
`define PSCD_DATA_CLOCK_OUT_DIV4 4'h4
`define PSCD_DATA_CLOCK_OUT_DIV8 4'h8
// Operating configuration codes with one-shot conversion
`define PSCD_OPC_OS_LOW 4'hC
`define PSCD_OPC_OS_MED 4'hD
`define PSCD_OPC_OS_FAST2 4'hE
`define PSCD_OPC_OS_FAST1 4'hF
// Status header field positions
`define PSCD_HDR_ERR 7
`define PSCD_HDR_UNSETTLED 6
`define PSCD_HDR_FILTER 5
`define PSCD_HDR_SAT 4
// Defaults held in serial control mode; reset loads all zero
`define PSCD_RST_FILTER 1'h1
`define PSCD_RST_DEC 2'h3
`define PSCD_RST_DATA_CLOCK_OUT 2'h3
`define PSCD_RST_FORMAT 2'h0

`endif

/* File: logic/pscd_pkg.sv */
// Types shared by the pin strap configuration decoder.
// Assumes the constants header is compiled alongside.
`default_nettype none
package pscd_pkg;

   typedef enum logic [1:0] {
      PSCD_PWR_LOW = 2'h0,
      PSCD_PWR_MEDIAN = 2'h1,
      PSCD_PWR_FAST = 2'h2
   } pscd_pwr_t;

   typedef struct packed {
      logic filter_sinc5;
      logic [1:0] dec_code;
      pscd_pwr_t pwr;
      logic [1:0] data_clock_out_code;
      logic one_shot;
      logic [1:0] out_format;
   } pscd_cfg_t;

   typedef struct packed {
      logic crc_err;
      logic mem_flip;
      logic clk_missing;
   } pscd_diag_t;

endpackage
`default_nettype wire

/* File: logic/pscd_pin_strap_config_decoder.sv */
// Pin strap configuration decoder for a multichannel converter.
// Assumes strap and event inputs synchronous to i_mclk, events as
// one-cycle pulses, diagnostics as levels from the converter core.
`timescale 1ns/1ps
`default_nettype none
`include "pscd_cfg.svh"

module pscd_pin_strap_config_decoder
   import pscd_pkg::*;
#(
   parameter int NUM_CH = `PSCD_NUM_CH
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ctrl_select,
   input wire logic i_filter_sel,
   input wire logic i_decimation_select_high,
   input wire logic i_decimation_select_low,
   input wire logic [3:0] i_operating_config_pins,
   input wire logic i_output_format_pin_low,
   input wire logic i_output_format_pin_high,
   input wire logic i_dev_reset,
   input wire logic i_supply_fault,
   input wire logic i_start,
   input wire logic i_sync_in,
   input wire pscd_diag_t i_diag,
   input wire logic [NUM_CH-1:0] i_filt_unsettled,
   input wire logic [NUM_CH-1:0] i_filt_saturated,
   output logic o_serial_mode,
   output pscd_cfg_t o_cfg,
   output logic [10:0] o_dec_ratio,
   output logic [5:0] o_modulator_rate,
   output logic [3:0] o_data_clock_divider,
   output pscd_pwr_t o_bias_level,
   output logic o_tdm_shared,
   output logic [NUM_CH-1:0] o_ain_precharge_en,
   output logic [NUM_CH-1:0] o_ref_precharge_en,
   output logic o_apply,
   output logic o_reset_req,
   output logic [NUM_CH*8-1:0] o_status_hdr
);

   logic boot_q;
   logic boot2_q;
   logic serial_q;
   pscd_cfg_t shadow_q;
   pscd_cfg_t active_q;
   pscd_cfg_t active_d;
   pscd_cfg_t strap_cfg;
   pscd_cfg_t rst_cfg;
   logic [1:0] opc_pwr;
   logic [1:0] opc_data_clock_out;
   logic opc_one_shot;
   logic pwrup_evt;
   logic apply_evt;
   logic err_q;
   logic err_d;
   logic err_set;
   logic apply_q;
   logic [10:0] dec_ratio_d;
   logic [10:0] dec_ratio_q;
   logic [5:0] mod_div_d;
   logic [5:0] mod_div_q;
   logic [3:0] data_clock_divider_d;
   logic [3:0] data_clock_divider_q;
   logic [NUM_CH-1:0] ain_q;
   logic [NUM_CH-1:0] ref_q;

   // Control select is a strap; caught on the first clock after release
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         boot_q <= 1'b0;
         boot2_q <= 1'b0;
         serial_q <= 1'b0;
      end
      else
      begin
         boot_q <= 1'b1;
         boot2_q <= boot_q;
         if (!boot_q)
         begin
            serial_q <= i_ctrl_select;
         end
      end
   end

   assign pwrup_evt = boot_q & ~boot2_q;

   // Operating configuration decode
   assign opc_one_shot = (i_operating_config_pins[3:2] == 2'h3);
   assign opc_pwr =
      (i_operating_config_pins == `PSCD_OPC_OS_LOW) ? PSCD_PWR_LOW :
      (i_operating_config_pins == `PSCD_OPC_OS_MED) ? PSCD_PWR_MEDIAN :
      opc_one_shot ? PSCD_PWR_FAST :
      (i_operating_config_pins[3:2] == 2'h0) ? PSCD_PWR_LOW :
      (i_operating_config_pins[3:2] == 2'h1) ? PSCD_PWR_MEDIAN :
      PSCD_PWR_FAST;
   assign opc_data_clock_out =
      (i_operating_config_pins == `PSCD_OPC_OS_FAST2) ? 2'h1 :
      opc_one_shot ? 2'h0 :
      i_operating_config_pins[1:0];

   assign strap_cfg.filter_sinc5 = i_filter_sel;
   assign strap_cfg.dec_code = {i_decimation_select_high,
                                i_decimation_select_low};
   assign strap_cfg.pwr = pscd_pwr_t'(opc_pwr);
   assign strap_cfg.data_clock_out_code = opc_data_clock_out;
   assign strap_cfg.one_shot = opc_one_shot;
   assign strap_cfg.out_format = {i_output_format_pin_high,
                                  i_output_format_pin_low};

   assign rst_cfg.filter_sinc5 = `PSCD_RST_FILTER;
   assign rst_cfg.dec_code = `PSCD_RST_DEC;
   assign rst_cfg.pwr = PSCD_PWR_LOW;
   assign rst_cfg.data_clock_out_code = `PSCD_RST_DATA_CLOCK_OUT;
   assign rst_cfg.one_shot = 1'b0;
   assign rst_cfg.out_format = `PSCD_RST_FORMAT;

   // Straps move freely; only an event lets them reach the core
   assign apply_evt = ~serial_q & (pwrup_evt | i_dev_reset |
      i_supply_fault | i_start | i_sync_in);
   // Serial path is outside this block, so its defaults are held
   assign active_d = serial_q ? rst_cfg :
      (apply_evt ? shadow_q : active_q);

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         shadow_q <= '0;
      end
      else
      begin
         shadow_q <= strap_cfg;
      end
   end

   // Reset value is all zero until the power-up apply or the serial defaults land
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         active_q <= '0;
      end
      else
      begin
         active_q <= active_d;
      end
   end

   // Derived settings from the applied configuration
   assign dec_ratio_d =
      (active_q.dec_code == 2'h0) ? `PSCD_DEC_X32 :
      (active_q.dec_code == 2'h1) ? `PSCD_DEC_X64 :
      (active_q.dec_code == 2'h2) ? `PSCD_DEC_X128 :
      `PSCD_DEC_X1024;
   assign mod_div_d =
      (active_q.pwr == PSCD_PWR_FAST) ? `PSCD_MOD_DIV_FAST :
      (active_q.pwr == PSCD_PWR_MEDIAN) ? `PSCD_MOD_DIV_MEDIAN :
      `PSCD_MOD_DIV_LOW;
   assign data_clock_divider_d =
      (active_q.data_clock_out_code == 2'h0) ? `PSCD_DATA_CLOCK_OUT_DIV1 :
      (active_q.data_clock_out_code == 2'h1) ? `PSCD_DATA_CLOCK_OUT_DIV2 :
      (active_q.data_clock_out_code == 2'h2) ? `PSCD_DATA_CLOCK_OUT_DIV4 :
      `PSCD_DATA_CLOCK_OUT_DIV8;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         dec_ratio_q <= `PSCD_DEC_X32;
      end
      else
      begin
         dec_ratio_q <= dec_ratio_d;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         mod_div_q <= `PSCD_MOD_DIV_LOW;
      end
      else
      begin
         mod_div_q <= mod_div_d;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         data_clock_divider_q <= `PSCD_DATA_CLOCK_OUT_DIV1;
      end
      else
      begin
         data_clock_divider_q <= data_clock_divider_d;
      end
   end

   // Marks the edge at which new straps reached the core
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         apply_q <= 1'b0;
      end
      else
      begin
         apply_q <= apply_evt;
      end
   end

   // Precharge defaults are fixed; no strap reaches them
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         ain_q <= '0;
         ref_q <= '0;
      end
      else
      begin
         ain_q <= '1;
         ref_q <= '0;
      end
   end

   // Sticky error; a fresh error beats the clearing reset
   assign err_set = i_diag.crc_err | i_diag.mem_flip |
      i_diag.clk_missing;
   assign err_d = err_set | (err_q & ~i_dev_reset);

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         err_q <= 1'b0;
      end
      else
      begin
         err_q <= err_d;
      end
   end

   // Header path reads only flags and the filter in use, so
   // readout never waits on configuration activity
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_hdr
         logic [7:0] hdr_d;
         logic [7:0] hdr_q;
         assign hdr_d[`PSCD_HDR_ERR] = err_q;
         assign hdr_d[`PSCD_HDR_UNSETTLED] =
            i_filt_unsettled[g];
         assign hdr_d[`PSCD_HDR_FILTER] =
            active_q.filter_sinc5;
         assign hdr_d[`PSCD_HDR_SAT] = i_filt_saturated[g];
         assign hdr_d[3] = 1'b0;
         assign hdr_d[2:0] = 3'(g);
         always_ff @(posedge i_mclk)
         begin
            if (!i_rst_n)
            begin
               hdr_q <= 8'h00;
            end
            else
            begin
               hdr_q <= hdr_d;
            end
         end
         assign o_status_hdr[g*8 +: 8] = hdr_q;
      end
   endgenerate

   assign o_serial_mode = serial_q;
   assign o_cfg = active_q;
   assign o_dec_ratio = dec_ratio_q;
   assign o_modulator_rate = mod_div_q;
   assign o_data_clock_divider = data_clock_divider_q;
   assign o_bias_level = active_q.pwr;
   assign o_tdm_shared = |active_q.out_format;
   assign o_ain_precharge_en = ain_q;
   assign o_ref_precharge_en = ref_q;
   assign o_apply = apply_q;
   assign o_reset_req = err_q;

endmodule // pscd_pin_strap_config_decoder
`default_nettype wire

/* File: tb/pscd_checker_properties.sv */
// Port checker for the strap decoder, bound into it.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module pscd_checker
   import pscd_pkg::*;
#(
   parameter int NUM_CH = 8
)
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_dev_reset,
   input wire logic i_supply_fault,
   input wire logic i_start,
   input wire logic i_sync_in,
   input wire logic [3:0] i_operating_config_pins,
   input wire pscd_diag_t i_diag,
   input wire logic o_serial_mode,
   input wire pscd_cfg_t o_cfg,
   input wire logic [10:0] o_dec_ratio,
   input wire logic [5:0] o_modulator_rate,
   input wire logic [3:0] o_data_clock_divider,
   input wire logic [NUM_CH-1:0] o_ain_precharge_en,
   input wire logic [NUM_CH-1:0] o_ref_precharge_en,
   input wire logic o_apply,
   input wire logic o_reset_req,
   input wire logic [NUM_CH*8-1:0] o_status_hdr
);
   wire logic ev = i_dev_reset | i_supply_fault | i_start | i_sync_in;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   // Rates lag the applied config by one edge
   property p_ratio;
      o_dec_ratio == ($past(o_cfg.dec_code) == 2'h3 ? 11'h400
         : 11'h020 << $past(o_cfg.dec_code));
   endproperty
   a_ratio: assert property (p_ratio)
      else $error("bad ratio");
   property p_mod;
      o_modulator_rate == ($past(o_cfg.pwr) == PSCD_PWR_FAST ? 6'h04
         : $past(o_cfg.pwr) == PSCD_PWR_MEDIAN ? 6'h08 : 6'h20);
   endproperty
   a_mod: assert property (p_mod)
      else $error("bad modulator rate");
   property p_data_clock_out;
      o_data_clock_divider == 4'h1 << $past(o_cfg.data_clock_out_code);
   endproperty
   a_data_clock_out: assert property (p_data_clock_out)
      else $error("bad divider");
   property p_pre;
      $past(i_rst_n) |-> &o_ain_precharge_en && !(|o_ref_precharge_en);
   endproperty
   a_pre: assert property (p_pre)
      else $error("bad precharge");
   property p_once;
      ev && !o_serial_mode && $past(i_rst_n) |=>
         o_cfg.one_shot == &$past(i_operating_config_pins[3:2], 2);
   endproperty
   a_once: assert property (p_once)
      else $error("bad one-shot");
   property p_err;
      |i_diag |=> o_reset_req ##1 o_status_hdr[7];
   endproperty
   a_err: assert property (p_err)
      else $error("error flag missing");
   // Power-up apply lands before the third edge
   property p_hold;
      $past(i_rst_n, 3) && !$stable(o_cfg) |-> $past(ev);
   endproperty
   a_hold: assert property (p_hold)
      else $error("config moved unasked");
   property p_apply;
      ev && !o_serial_mode && $past(i_rst_n) |=> o_apply;
   endproperty
   a_apply: assert property (p_apply)
      else $error("no apply pulse");
endmodule // pscd_checker
bind pscd_pin_strap_config_decoder pscd_checker #(.NUM_CH(NUM_CH)) i_chk (
   .i_mclk, .i_rst_n, .i_dev_reset, .i_supply_fault, .i_start, .i_sync_in,
   .i_operating_config_pins, .i_diag, .o_serial_mode, .o_cfg, .o_dec_ratio,
   .o_modulator_rate, .o_data_clock_divider, .o_ain_precharge_en,
   .o_ref_precharge_en, .o_apply, .o_reset_req, .o_status_hdr);
`default_nettype wire

/* File: tb/pscd_host_model.sv */
// Host model driving strap pins, start, sync and soft reset.
// Assumes one request at a time from the bench.
`timescale 1ns/1ps
`default_nettype none
module pscd_host_model
(
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_go,
   input wire logic [1:0] i_pick,
   input wire logic i_clr,
   input wire logic [8:0] i_straps,
   output logic [8:0] o_straps = 9'h000,
   output logic o_start = 1'b0,
   output logic o_sync = 1'b0,
   output logic o_dev_reset = 1'b0
);
   logic go_q = 1'b0;
   logic [1:0] cnt_q = 2'h0;
   // Straps settle a full cycle before the pulse
   always @(posedge i_mclk)
   begin
      go_q <= i_go;
      if (i_go)
         o_straps <= i_straps;
      o_start <= go_q & i_pick[0];
      o_sync <= go_q & i_pick[1];
      cnt_q <= !i_rst_n ? 2'h0 : cnt_q + 2'(cnt_q != 2'h3);
      o_dev_reset <= cnt_q == 2'h2 || i_clr;
   end
endmodule // pscd_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the strap configuration decoder.
// Assumes host model and bound checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import pscd_pkg::*;
();
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_ctrl_select = 1'b0;
   logic i_supply_fault = 1'b0;
   pscd_diag_t i_diag = '0;
   logic [7:0] fu = 8'hA5;
   logic [7:0] fs = 8'h3C;
   logic go = 1'b0;
   logic clr = 1'b0;
   logic [1:0] pick = 2'h0;
   logic [8:0] straps = 9'h000;
   logic [8:0] sv;
   logic i_start, i_sync_in, i_dev_reset, o_serial_mode, o_apply;
   logic o_reset_req, o_tdm_shared;
   pscd_cfg_t o_cfg;
   pscd_pwr_t o_bias_level;
   logic [10:0] o_dec_ratio;
   logic [5:0] o_modulator_rate;
   logic [3:0] o_data_clock_divider;
   logic [7:0] o_ain_precharge_en, o_ref_precharge_en;
   logic [63:0] o_status_hdr;
   logic [19:0] r;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [10:0] dr [4] = '{11'h020, 11'h040, 11'h080, 11'h400};
   // Row: code, power, modulator division, data clock division
   logic [19:0] rows [16] = '{20'h00201, 20'h10202, 20'h20204, 20'h30208,
      20'h41081, 20'h51082, 20'h61084, 20'h71088, 20'h82041, 20'h92042,
      20'hA2044, 20'hB2048, 20'hC0201, 20'hD1081, 20'hE2042, 20'hF2041};
   pscd_pin_strap_config_decoder #(.NUM_CH(8))
      i_pscd_pin_strap_config_decoder (
      .i_mclk, .i_rst_n, .i_ctrl_select, .i_filter_sel(sv[8]),
      .i_decimation_select_high(sv[7]), .i_decimation_select_low(sv[6]),
      .i_operating_config_pins(sv[5:2]), .i_output_format_pin_high(sv[1]),
      .i_output_format_pin_low(sv[0]), .i_dev_reset, .i_supply_fault,
      .i_start, .i_sync_in, .i_diag, .i_filt_unsettled(fu),
      .i_filt_saturated(fs), .o_serial_mode, .o_cfg, .o_dec_ratio,
      .o_modulator_rate, .o_data_clock_divider, .o_bias_level, .o_tdm_shared,
      .o_ain_precharge_en, .o_ref_precharge_en, .o_apply, .o_reset_req,
      .o_status_hdr);
   pscd_host_model i_pscd_host_model (.i_mclk, .i_rst_n, .i_go(go),
      .i_pick(pick), .i_clr(clr), .i_straps(straps), .o_straps(sv),
      .o_start(i_start), .o_sync(i_sync_in), .o_dev_reset(i_dev_reset));
   always #10 i_mclk = ~i_mclk;
   task chk(input logic [10:0] got, input logic [10:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task send(input logic [8:0] s, input logic [1:0] p);
      @(posedge i_mclk) go <= 1'b1;
      straps <= s;
      pick <= p;
      @(posedge i_mclk) go <= 1'b0;
   endtask
   task summarize;
      $display("checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Whole run needs well under 600 cycles
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         summarize();
      end
   end
   initial
   begin
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      wt(8);
      chk(o_serial_mode, 1'b0);
      chk(o_dec_ratio, 11'h020);
      chk(o_ain_precharge_en, 11'h0FF);
      chk(o_ref_precharge_en, 11'h000);
      $display("reset test done");
      for (int i = 0; i < 16; i++)
      begin
         r = rows[i];
         send({i[0], i[1:0], r[19:16], i[3:2]}, {i[0], ~i[0]});
         wt(5);
         chk(o_bias_level, r[15:12]);
         chk(o_modulator_rate, r[11:4]);
         chk(o_data_clock_divider, r[3:0]);
         chk(o_cfg.one_shot, &r[19:18]);
         chk(o_dec_ratio, dr[i[1:0]]);
         chk(o_cfg.filter_sinc5, i[0]);
         chk(o_status_hdr[61], i[0]);
         chk(o_tdm_shared, i[3:2] != 2'h0);
      end
      $display("table test done");
      send(9'h000, 2'h0);
      wt(5);
      chk(o_dec_ratio, 11'h400);
      @(posedge i_mclk) i_supply_fault <= 1'b1;
      @(posedge i_mclk) i_supply_fault <= 1'b0;
      #1;
      chk(o_apply, 1'b1);
      wt(4);
      chk(o_apply, 1'b0);
      chk(o_dec_ratio, 11'h020);
      for (int g = 0; g < 8; g++)
         chk(o_status_hdr[g*8+:8],
            {1'b0, fu[g], 1'b0, fs[g], 1'b0, 3'(g)});
      for (int k = 0; k < 3; k++)
      begin
         @(posedge i_mclk) i_diag <= 3'h1 << k;
         @(posedge i_mclk) i_diag <= 3'h0;
         wt(3);
         chk(o_status_hdr[23], 1'b1);
         @(posedge i_mclk) clr <= 1'b1;
         @(posedge i_mclk) clr <= 1'b0;
         wt(4);
         chk(o_reset_req, 1'b0);
      end
      // Clear and fresh error meet at one edge; the error must stay
      @(posedge i_mclk) clr <= 1'b1;
      @(posedge i_mclk) clr <= 1'b0;
      i_diag <= 3'h4;
      @(posedge i_mclk) i_diag <= 3'h0;
      wt(2);
      chk(o_reset_req, 1'b1);
      $display("fault test done");
      @(posedge i_mclk) i_rst_n <= 1'b0;
      i_ctrl_select <= 1'b1;
      wt(3);
      @(posedge i_mclk) i_rst_n <= 1'b1;
      wt(8);
      chk(o_dec_ratio, 11'h400);
      chk(o_data_clock_divider, 11'h008);
      i_ctrl_select <= 1'b0;
      send(9'h03C, 2'h3);
      wt(5);
      chk(o_serial_mode, 1'b1);
      chk(o_cfg.one_shot, 1'b0);
      $display("serial test done");
      summarize();
   end
endmodule // tb_top
`default_nettype wire
